/* File: logic/amt_regs.sv */
`timescale 1ns/100ps
module amt_regs
  import amt_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int BIST_LEN = BIST_CYCLES
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire amt_wr_t wr_in,
  input wire logic rd_en_in,
  input wire logic [7:0] rd_addr_in,
  output logic [7:0] rdata_out,
  input wire logic [W-1:0] sample_in,
  input wire logic [W-1:0] user_pattern_in,
  output logic power_down_out,
  output logic standby_out,
  output logic digital_reset_out,
  output logic dcs_enable_out,
  output logic [3:0] div_ratio_out,
  output logic word_strobe_out,
  output logic [W-1:0] data_out,
  output logic bist_busy_out,
  output logic [15:0] bist_signature_out
);
  // Register contents.
  logic [7:0] modes_r;
  logic [7:0] clock_r;
  logic [7:0] clkdiv_r;
  logic [7:0] test_r;
  logic [7:0] bist_r;
  logic [7:0] offset_r;
  // Divider count and the one-cycle output word tick.
  logic [2:0] div_cnt_r;
  logic word_tick;
  // Pattern generators.
  logic [22:0] pn23_r;
  logic [8:0] pn9_r;
  logic toggle_r;
  logic sync_done_r;
  logic [W-1:0] mix_cnt_r;
  logic [W-1:0] pattern;
  // Self-test sequencer.
  typedef enum logic {BS_IDLE, BS_RUN} amt_bist_t;
  amt_bist_t bst_r;
  logic [15:0] bist_cnt_r;
  logic [15:0] misr_r;
  logic [8:0] bist_lfsr_r;
  logic bist_done;
  logic running;
  logic [3:0] tmode;

  assign tmode = test_r[3:0];
  assign running = (modes_r[1:0] == MODE_RUN);

  // Adds the signed trim to an offset binary word and clamps at both rails.
  function automatic logic [W-1:0] sat_add(input logic [W-1:0] d, input logic [7:0] off);
    logic signed [W+1:0] s;
    s = $signed({2'b00, d}) + $signed({{(W-6){off[7]}}, off});
    if (s < 0) begin
      sat_add = '0;
    end else if (s > $signed({2'b00, {W{1'b1}}})) begin
      sat_add = '1;
    end else begin
      sat_add = s[W-1:0];
    end
  endfunction

  // Register writes; a host write wins over the self-test clearing its start bit.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      modes_r <= RST_MODES;
      clock_r <= RST_CLOCK;
      clkdiv_r <= RST_CLKDIV;
      test_r <= RST_TEST;
      bist_r <= RST_BIST;
      offset_r <= RST_OFFSET;
    end else begin
      if (wr_in.en) begin
        if (wr_in.addr == ADDR_MODES) begin
          modes_r <= wr_in.data;
        end else if (wr_in.addr == ADDR_CLOCK) begin
          clock_r <= wr_in.data;
        end else if (wr_in.addr == ADDR_CLKDIV) begin
          clkdiv_r <= wr_in.data;
        end else if (wr_in.addr == ADDR_TEST) begin
          test_r <= wr_in.data;
        end else if (wr_in.addr == ADDR_BIST) begin
          bist_r <= wr_in.data;
        end else if (wr_in.addr == ADDR_OFFSET) begin
          offset_r <= wr_in.data;
        end
      end
      // Initialize is a one-shot; start drops when a run completes. Writes to
      // other registers must not mask these clears, or a run would repeat.
      if (!(wr_in.en && wr_in.addr == ADDR_BIST)) begin
        bist_r[SELF_TEST_INITIALIZE_BIT] <= 1'b0;
        if (bist_done) begin
          bist_r[BIST_START_BIT] <= 1'b0;
        end
      end
    end
  end

  // Read port; unmapped addresses read as zero.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_en_in) begin
      if (rd_addr_in == ADDR_MODES) begin
        rdata_out <= modes_r;
      end else if (rd_addr_in == ADDR_CLOCK) begin
        rdata_out <= clock_r;
      end else if (rd_addr_in == ADDR_CLKDIV) begin
        rdata_out <= clkdiv_r;
      end else if (rd_addr_in == ADDR_TEST) begin
        rdata_out <= test_r;
      end else if (rd_addr_in == ADDR_BIST) begin
        rdata_out <= bist_r;
      end else if (rd_addr_in == ADDR_OFFSET) begin
        rdata_out <= offset_r;
      end else begin
        rdata_out <= 8'h00;
      end
    end
  end

  // Mode decode and static controls, registered for clean outputs.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      power_down_out <= 1'b0;
      standby_out <= 1'b0;
      digital_reset_out <= 1'b0;
      dcs_enable_out <= RST_CLOCK[DCS_BIT];
      div_ratio_out <= {1'b0, RST_CLKDIV[2:0]} + 4'h1;
    end else begin
      power_down_out <= (modes_r[1:0] == MODE_PDWN);
      standby_out <= (modes_r[1:0] == MODE_STBY);
      digital_reset_out <= (modes_r[1:0] == MODE_DRST);
      dcs_enable_out <= clock_r[DCS_BIT];
      div_ratio_out <= {1'b0, clkdiv_r[2:0]} + 4'h1;
    end
  end

  // Input clock divider. The compare is >= so a smaller ratio written
  // mid-count takes effect at once instead of wrapping through eight.
  assign word_tick = (div_cnt_r >= clkdiv_r[2:0]);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      div_cnt_r <= 3'h0;
    end else if (word_tick) begin
      div_cnt_r <= 3'h0;
    end else begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

  // Pattern generators step once per output word. Every mode other than chip run, and the
  // generator reset bits, hold them at their seeds.
  always_ff @(posedge clk_in) begin
    if (srst_in || !running || test_r[PN_LONG_RST_BIT]) begin
      pn23_r <= '1;
    end else if (word_tick) begin
      pn23_r <= {pn23_r[21:0], pn23_r[22] ^ pn23_r[17]};
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in || !running || test_r[PN_SHORT_RST_BIT]) begin
      pn9_r <= '1;
    end else if (word_tick) begin
      pn9_r <= {pn9_r[7:0], pn9_r[8] ^ pn9_r[4]};
    end
  end

  // Word toggle, one-shot sync and mixed frequency counter.
  always_ff @(posedge clk_in) begin
    if (srst_in || !running || tmode == TM_OFF) begin
      toggle_r <= 1'b0;
      sync_done_r <= 1'b0;
      mix_cnt_r <= '0;
    end else if (word_tick) begin
      toggle_r <= !toggle_r;
      sync_done_r <= 1'b1;
      mix_cnt_r <= mix_cnt_r + 1'b1;
    end
  end

  // Pattern selection. Undefined codes give zeros rather than stale data.
  always_comb begin
    pattern = '0;
    case (tmode)
      TM_MID: pattern = {1'b1, {(W-1){1'b0}}};
      TM_POS_FS: pattern = '1;
      TM_NEG_FS: pattern = '0;
      TM_CHECK: pattern = toggle_r ? {(W/2){2'b01}} : {(W/2){2'b10}};
      TM_PN23: pattern = pn23_r[22:23-W];
      // The 9-bit generator is shorter than a word, so it is laid twice side by side.
      TM_PN9: pattern = W'({pn9_r, pn9_r} >> (18 - W));
      TM_WTOG: pattern = toggle_r ? '0 : '1;
      TM_USER: pattern = user_pattern_in;
      TM_BTOG: pattern = {(W/2){2'b10}};
      TM_SYNC: pattern = sync_done_r ? '0 : '1;
      TM_ONEHI: pattern = {{(W-1){1'b0}}, 1'b1};
      TM_MIXED: pattern = mix_cnt_r;
      default: pattern = '0;
    endcase
  end

  // Output word register. Only the chip-run mode produces data.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      data_out <= '0;
      word_strobe_out <= 1'b0;
    end else if (!running) begin
      data_out <= '0;
      word_strobe_out <= 1'b0;
    end else begin
      word_strobe_out <= word_tick;
      if (word_tick) begin
        if (tmode == TM_OFF) begin
          data_out <= sat_add(sample_in, offset_r);
        end else begin
          data_out <= pattern;
        end
      end
    end
  end

  // Self-test: a PN9 stimulus folded into a signature register. The run is
  // a fixed length so the signature can be compared against a golden value.
  assign bist_done = (bst_r == BS_RUN) && (bist_cnt_r == 16'(BIST_LEN - 1));
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bst_r <= BS_IDLE;
      bist_cnt_r <= 16'h0000;
    end else begin
      case (bst_r)
        BS_IDLE: begin
          bist_cnt_r <= 16'h0000;
          if (bist_r[BIST_START_BIT] && !bist_r[SELF_TEST_INITIALIZE_BIT]) begin
            bst_r <= BS_RUN;
          end
        end
        BS_RUN: begin
          bist_cnt_r <= bist_cnt_r + 16'h0001;
          if (bist_done || bist_r[SELF_TEST_INITIALIZE_BIT]) begin
            bst_r <= BS_IDLE;
          end
        end
        default: bst_r <= BS_IDLE;
      endcase
    end
  end

  // Generator and signature; initialize returns both to their seeds.
  always_ff @(posedge clk_in) begin
    if (srst_in || bist_r[SELF_TEST_INITIALIZE_BIT]) begin
      bist_lfsr_r <= '1;
      misr_r <= 16'h0000;
    end else if (bst_r == BS_RUN) begin
      bist_lfsr_r <= {bist_lfsr_r[7:0], bist_lfsr_r[8] ^ bist_lfsr_r[4]};
      misr_r <= {misr_r[14:0], misr_r[15] ^ misr_r[12] ^ misr_r[3]} ^ {7'h00, bist_lfsr_r};
    end
  end

  // Status outputs.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bist_busy_out <= 1'b0;
      bist_signature_out <= 16'h0000;
    end else begin
      bist_busy_out <= (bst_r == BS_RUN);
      bist_signature_out <= misr_r;
    end
  end

  // Checks on the logic above.
  default clocking cb @(posedge clk_in); endclocking

  a_mode_decode: assert property (disable iff (srst_in) (modes_r[1:0] == MODE_PDWN) |=> power_down_out)
    else $error("power-down not decoded");
  a_dcs_reset: assert property (srst_in |=> clock_r == RST_CLOCK ##1 dcs_enable_out)
    else $error("stabilizer not enabled after reset");
  a_div_period: assert property (disable iff (srst_in)
    word_tick && clkdiv_r[2:0] == 3'h1 && !wr_in.en ##1 !wr_in.en |-> !word_tick ##1 word_tick)
    else $error("divide by two period wrong");
  a_normal_data: assert property (disable iff (srst_in)
    word_tick && running && tmode == TM_OFF |=> data_out == sat_add($past(sample_in), $past(offset_r)))
    else $error("trimmed sample wrong");
  a_fs_codes: assert property (disable iff (srst_in)
    word_tick && running && tmode == TM_POS_FS |=> data_out == '1)
    else $error("positive full scale wrong");
  a_checker_alt: assert property (disable iff (srst_in)
    word_tick && running && tmode == TM_CHECK ##1 word_tick && running && tmode == TM_CHECK
    |=> data_out == ~$past(data_out))
    else $error("checkerboard did not alternate");
  a_pn9_step: assert property (disable iff (srst_in)
    word_tick && running && !test_r[PN_SHORT_RST_BIT] |=> pn9_r == {$past(pn9_r[7:0]), $past(pn9_r[8] ^ pn9_r[4])})
    else $error("PN9 step wrong");
  a_word_toggle: assert property (disable iff (srst_in)
    word_tick && running && tmode == TM_WTOG |=> data_out == '1 || data_out == '0)
    else $error("word toggle not rail");
  a_user_pat: assert property (disable iff (srst_in)
    word_tick && running && tmode == TM_USER |=> data_out == $past(user_pattern_in))
    else $error("user pattern not output");
  a_test_subst: assert property (disable iff (srst_in)
    word_tick && running && tmode != TM_OFF |=> data_out == $past(pattern))
    else $error("test data not substituted");
  a_bist_start: assert property (disable iff (srst_in)
    bst_r == BS_IDLE && bist_r[BIST_START_BIT] && !bist_r[SELF_TEST_INITIALIZE_BIT] |=> bst_r == BS_RUN ##1 bist_busy_out)
    else $error("self-test did not start");
  a_self_test_initialize: assert property (disable iff (srst_in) bist_r[SELF_TEST_INITIALIZE_BIT] |=> misr_r == 16'h0000)
    else $error("signature not cleared");

  c_power_down: cover property (disable iff (srst_in) power_down_out);
  c_pn23_out: cover property (disable iff (srst_in) word_strobe_out && tmode == TM_PN23);
  c_div_eight: cover property (disable iff (srst_in) div_ratio_out == 4'h8 && word_tick);
  c_bist_done: cover property (disable iff (srst_in) bist_done);
endmodule

/* File: logic/amt_pkg.sv */
package amt_pkg;
  // Width of one converted sample word.
  localparam int DATA_W = 10;
  // Register offsets on the configuration port.
  localparam logic [7:0] ADDR_MODES = 8'h08;
  localparam logic [7:0] ADDR_CLOCK = 8'h09;
  localparam logic [7:0] ADDR_CLKDIV = 8'h0b;
  localparam logic [7:0] ADDR_TEST = 8'h0d;
  localparam logic [7:0] ADDR_BIST = 8'h0e;
  localparam logic [7:0] ADDR_OFFSET = 8'h10;
  // Values after reset.
  localparam logic [7:0] RST_MODES = 8'h00;
  localparam logic [7:0] RST_CLOCK = 8'h01;
  localparam logic [7:0] RST_CLKDIV = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_BIST = 8'h00;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  // Field positions.
  localparam int DCS_BIT = 0;
  localparam int PN_LONG_RST_BIT = 5;
  localparam int PN_SHORT_RST_BIT = 4;
  localparam int BIST_START_BIT = 0;
  localparam int SELF_TEST_INITIALIZE_BIT = 2;
  // Operating modes in the low two bits of the mode register.
  typedef enum logic [1:0] {
    MODE_RUN = 2'h0,
    MODE_PDWN = 2'h1,
    MODE_STBY = 2'h2,
    MODE_DRST = 2'h3
  } amt_mode_t;
  // Output test pattern codes.
  localparam logic [3:0] TM_OFF = 4'h0;
  localparam logic [3:0] TM_MID = 4'h1;
  localparam logic [3:0] TM_POS_FS = 4'h2;
  localparam logic [3:0] TM_NEG_FS = 4'h3;
  localparam logic [3:0] TM_CHECK = 4'h4;
  localparam logic [3:0] TM_PN23 = 4'h5;
  localparam logic [3:0] TM_PN9 = 4'h6;
  localparam logic [3:0] TM_WTOG = 4'h7;
  localparam logic [3:0] TM_USER = 4'h8;
  localparam logic [3:0] TM_BTOG = 4'h9;
  localparam logic [3:0] TM_SYNC = 4'ha;
  localparam logic [3:0] TM_ONEHI = 4'hb;
  localparam logic [3:0] TM_MIXED = 4'hc;
  // Self-test run length in cycles.
  localparam int BIST_CYCLES = 1024;
  // One register write from the serial port engine.
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } amt_wr_t;
endpackage

/* File: verif/amt_host.sv */
`timescale 1ns/100ps
// Host on the configuration byte port; requests change 1 ns after a rising edge.
module amt_host
  import amt_pkg::*;
(
  input wire logic clk_in,
  output amt_wr_t wr_out,
  output logic rd_en_out,
  output logic [7:0] rd_addr_out,
  input wire logic [7:0] rdata_in
);
  // Idle bus shows inverted values so a stale address is never mistaken for a live one.
  initial begin
    wr_out = '{1'b0, 8'hff, 8'hff};
    rd_en_out = 1'b0;
    rd_addr_out = 8'hff;
  end
  // One write: strobe held for exactly one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1 wr_out = '{1'b1, a, d};
    @(posedge clk_in);
    #1 wr_out = '{1'b0, ~a, ~d};
  endtask
  // One read: data is registered, so it is taken one cycle after the request edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1 rd_en_out = 1'b1;
    rd_addr_out = a;
    @(posedge clk_in);
    #1 rd_en_out = 1'b0;
    rd_addr_out = ~a;
    d = rdata_in;
  endtask
endmodule

/* File: verif/adc_mode_test_config_regs_tb.sv */
`timescale 1ns/100ps
module adc_mode_test_config_regs_tb;
  import amt_pkg::*;
  localparam int BL = 16; // Short self-test run keeps the run brief.
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  amt_wr_t wr_w;
  logic rd_en_w;
  logic [7:0] rd_addr_w, rdata_w, rv;
  logic [DATA_W-1:0] samp_r = 10'h123;
  logic [DATA_W-1:0] user_r = 10'h2c6;
  logic [DATA_W-1:0] data_w, w0, w1;
  logic pd_w, sb_w, dr_w, dcs_w, strobe_w, busy_w;
  logic [3:0] div_w;
  logic [15:0] sig_w;
  int n_fail = 0;
  int cmp_count = 0;
  int k;
  logic [7:0] addrs[7] = '{ADDR_MODES, ADDR_CLOCK, ADDR_CLKDIV, ADDR_TEST, ADDR_BIST, ADDR_OFFSET, 8'h0a};
  logic [7:0] rsts[7] = '{RST_MODES, RST_CLOCK, RST_CLKDIV, RST_TEST, RST_BIST, RST_OFFSET, 8'h00};
  logic [3:0] codes[7] = '{TM_OFF, TM_MID, TM_POS_FS, TM_NEG_FS, TM_USER, TM_BTOG, TM_ONEHI};
  logic [9:0] pats[7] = '{10'h123, 10'h200, 10'h3ff, 10'h000, 10'h2c6, 10'h2aa, 10'h001};
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  amt_host host (.clk_in(clk_in), .wr_out(wr_w), .rd_en_out(rd_en_w), .rd_addr_out(rd_addr_w), .rdata_in(rdata_w));
  amt_regs #(.W(DATA_W), .BIST_LEN(BL)) uut (.clk_in(clk_in), .srst_in(srst_in), .wr_in(wr_w), .rd_en_in(rd_en_w),
    .rd_addr_in(rd_addr_w), .rdata_out(rdata_w), .sample_in(samp_r), .user_pattern_in(user_r),
    .power_down_out(pd_w), .standby_out(sb_w), .digital_reset_out(dr_w), .dcs_enable_out(dcs_w),
    .div_ratio_out(div_w), .word_strobe_out(strobe_w), .data_out(data_w), .bist_busy_out(busy_w),
    .bist_signature_out(sig_w));
  // Compare one value; unknowns never match.
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Next output word, taken in the cycle its strobe stands.
  task automatic word(output logic [9:0] w);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_in);
      #2;
      if (strobe_w === 1'b1) begin
        w = data_w;
        return;
      end
    end
    chk("strobe wait", 16'h1, 16'h0);
    conclude();
  endtask
  // Poll busy until it equals v, bounded.
  task automatic wait_busy(input logic v, output int n);
    for (n = 0; busy_w !== v; n++) begin
      cyc(1);
      if (n > 100) begin
        chk("busy wait", 16'(v), 16'(busy_w));
        conclude();
      end
    end
  endtask
  initial begin
    cyc(8);
    srst_in = 1'b0;
    chk("dcs reset", 16'h1, 16'(dcs_w));
    chk("div reset", 16'h1, 16'(div_w));
    // Every other status output must come out of reset low.
    chk("outputs reset", 16'h0, 16'({pd_w, sb_w, dr_w, strobe_w, busy_w, data_w}));
    chk("signature reset", 16'h0, sig_w);
    for (int i = 0; i < 7; i++) begin
      host.rd(addrs[i], rv);
      chk("reg reset", 16'(rsts[i]), 16'(rv));
    end
    for (int m = 0; m < 4; m++) begin
      host.wr(ADDR_MODES, 8'(m));
      cyc(2);
      chk("mode decode", 16'({m == 1, m == 2, m == 3}), 16'({pd_w, sb_w, dr_w}));
      if (m == 1) begin
        repeat (10) begin
          cyc(1);
          chk("strobe in power-down", 16'h0, 16'(strobe_w));
        end
      end
    end
    host.wr(ADDR_MODES, 8'h00);
    host.wr(ADDR_CLOCK, 8'h00);
    cyc(2);
    chk("dcs off", 16'h0, 16'(dcs_w));
    for (int d = 0; d < 8; d++) begin
      host.wr(ADDR_CLKDIV, 8'(d));
      cyc(2);
      chk("div ratio", 16'(d + 1), 16'(div_w));
    end
    // Divide by eight: strobes must stand eight clocks apart.
    word(w0);
    k = 0;
    do begin
      @(posedge clk_in);
      #2;
      k++;
    end while (strobe_w !== 1'b1 && k < 20);
    chk("divide period", 16'h8, 16'(k));
    host.wr(ADDR_CLKDIV, 8'h00);
    for (int i = 0; i < 7; i++) begin
      host.wr(ADDR_TEST, {4'h0, codes[i]});
      word(w0);
      word(w0);
      chk("fixed pattern", 16'(pats[i]), 16'(w0));
    end
    host.wr(ADDR_TEST, {4'h0, TM_CHECK});
    word(w0);
    word(w0);
    word(w1);
    chk("checkerboard pair", 16'h3ff, 16'(w0 ^ w1));
    chk("checkerboard word", 16'h1, 16'(w0 == 10'h155 || w0 == 10'h2aa));
    host.wr(ADDR_TEST, {4'h0, TM_WTOG});
    word(w0);
    word(w0);
    word(w1);
    chk("word toggle", 16'h3ff, 16'(w0 ^ w1));
    chk("word toggle level", 16'h1, 16'(w0 == 10'h000 || w0 == 10'h3ff));
    host.wr(ADDR_TEST, {4'h0, TM_PN9});
    word(w0);
    word(w0);
    word(w1);
    chk("pn9 moves", 16'h1, 16'(w0 != w1));
    chk("pn9 shift", 16'(w0[8:1]), 16'(w1[9:2]));
    // A set generator reset bit holds the seed of all ones.
    host.wr(ADDR_TEST, 8'h16);
    word(w0);
    word(w0);
    chk("pn9 held", 16'h3ff, 16'(w0));
    host.wr(ADDR_TEST, {4'h0, TM_PN23});
    word(w0);
    word(w0);
    word(w1);
    chk("pn23 shift", 16'(w0[8:0]), 16'(w1[9:1]));
    host.wr(ADDR_TEST, 8'h25);
    word(w0);
    word(w0);
    chk("pn23 held", 16'h3ff, 16'(w0));
    // Mixed frequency steps by one per word; undefined codes give zeros.
    host.wr(ADDR_TEST, {4'h0, TM_MIXED});
    word(w0);
    word(w0);
    word(w1);
    chk("mixed step", 16'h1, 16'(10'(w1 - w0)));
    host.wr(ADDR_TEST, 8'h0d);
    word(w0);
    word(w0);
    chk("undefined code", 16'h0, 16'(w0));
    host.wr(ADDR_TEST, {4'h0, TM_OFF});
    samp_r = 10'h100;
    host.wr(ADDR_OFFSET, 8'h05);
    host.rd(ADDR_OFFSET, rv);
    chk("offset readback", 16'h05, 16'(rv));
    word(w0);
    word(w0);
    chk("offset plus", 16'h105, 16'(w0));
    samp_r = 10'h010;
    host.wr(ADDR_OFFSET, 8'h80);
    word(w0);
    word(w0);
    chk("offset floor", 16'h000, 16'(w0));
    samp_r = 10'h3f0;
    host.wr(ADDR_OFFSET, 8'h7f);
    word(w0);
    word(w0);
    chk("offset ceiling", 16'h3ff, 16'(w0));
    // Sync from the off code: one all-ones word, then zeros.
    host.wr(ADDR_TEST, {4'h0, TM_SYNC});
    word(w0);
    word(w1);
    chk("sync word", 16'h3ff, 16'(w0));
    chk("after sync", 16'h000, 16'(w1));
    host.wr(ADDR_BIST, 8'h01);
    wait_busy(1'b1, k);
    chk("bist start delay", 16'h1, 16'(k <= 3));
    wait_busy(1'b0, k);
    chk("bist length", 16'h1, 16'(k >= BL - 2 && k <= BL));
    chk("bist signature", 16'h1, 16'(sig_w != 16'h0000));
    host.rd(ADDR_BIST, rv);
    chk("bist bit clears", 16'h00, 16'(rv));
    host.wr(ADDR_BIST, 8'h01);
    wait_busy(1'b1, k);
    host.wr(ADDR_BIST, 8'h04);
    cyc(4);
    chk("init aborts", 16'h0, 16'(busy_w));
    chk("init signature", 16'h0, sig_w);
    host.rd(ADDR_BIST, rv);
    chk("init self-clears", 16'h00, 16'(rv));
    conclude();
  end
endmodule
